// ===== src/cseq_core.v
/*
 * Sequencing core: program counter, stack pointer, processing states,
 * exception priority, reset and stop-clear handling, register port.
 * Assumes a decoder presents one operation per cycle on op_i and that
 * the ALU, RAM and peripherals are outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cseq_defines.vh"

// Functional notes
// - Keep a 14-bit program counter pointing to the next instruction.
// - Stack pointer is 10 bits, next empty slot, reset to 3ff.
// - Stack pointer drops four per call save, rises four per return.
// - Top four stack pointer bits are always ones: sixteen levels.
// - Clearing the stack reset bit reloads the stack pointer.
// - Register-indirect RAM address built from W, X and Y.
// - Direct RAM address is the second instruction word.
// - Memory register op: 6-bit opcode, 4-bit register select.
// - Memory registers map to RAM digits 040 through 04f.
// - Long jump target: first word low 4 bits above second word.
// - Current-page branch replaces the low 8 bits only.
// - Zero-page branch uses a 6-bit field, upper bits zero.
// - Table address joins a 4-bit field with A and B.
// - Table fetch steers data to A/B, R1/R2 or both; PC kept.
// - INT0 or timer A in watch with low-speed set gives subactive.
// - Interrupt entry pushes PC, carry and status.
// - Stop in active with watch-select clear enters stop mode.
// - Watch entered from active stop or subactive stop/sleep.
// - Sleep in active mode enters standby, CPU clock gated.
// - Priority: reset, stop clear, interrupt after instruction.
// - Reset pin high resets asynchronously; enabled watchdog overflow resets one cycle later.
// - Stop-clear pin low in stop mode clears it into reset.
// - Pin or watchdog reset clears RAM-valid and interrupt enable.
// - After reset fetch starts at address 0000.
// - Stop clear follows reset sequence but sets RAM-valid.
module cseq_core #(
   parameter PC_W = `CSEQ_PC_W,
   parameter SP_W = `CSEQ_SP_W
) (
   input  wire            core_clk_i,
   input  wire            rst_i,
   input  wire            wdt_overflow_i,
   input  wire            stop_clear_pin_n_i,
   input  wire            instr_done_i,
   input  wire [3:0]      op_i,
   input  wire [1:0]      ram_mode_i,
   input  wire [9:0]      word1_i,
   input  wire [9:0]      word2_i,
   input  wire            cond_i,
   input  wire [1:0]      w_reg_i,
   input  wire [3:0]      x_reg_i,
   input  wire [3:0]      y_reg_i,
   input  wire [3:0]      acc_i,
   input  wire [3:0]      b_reg_i,
   input  wire [9:0]      rom_data_i,
   input  wire            carry_flag_i,
   input  wire            status_flag_i,
   input  wire            irq_req_i,
   input  wire [13:0]     irq_vector_i,
   input  wire            wake_irq_i,
   input  wire [3:0]      reg_addr_i,
   input  wire [7:0]      reg_wdata_i,
   input  wire            reg_wr_i,
   input  wire            reg_rd_i,
   output reg  [7:0]      reg_rdata_o,
   output reg  [PC_W-1:0] pc_o,
   output reg  [SP_W-1:0] sp_o,
   output wire [9:0]      ram_addr_o,
   output wire [13:0]     tbl_addr_o,
   output reg             push_o,
   output reg  [15:0]     push_data_o,
   output reg  [7:0]      tbl_data_o,
   output reg             tbl_to_ab_o,
   output reg             tbl_to_port_o,
   output reg             ram_valid_flag_o,
   output reg             global_irq_enable_o,
   output wire            cpu_clk_en_o,
   output wire            sub_clk_sel_o,
   output wire            sys_osc_en_o,
   output wire            periph_reset_o,
   output wire            adc_halt_o,
   output wire [4:0]      mode_o
);
   // ----------------------------------------------------------------
   // Processing states
   // ----------------------------------------------------------------
   // One-hot; bits 0 and 1 are the states in which the CPU executes,
   // which is what running and the op gate rely on
   localparam [4:0] M_ACTIVE  = 5'h01;
   localparam [4:0] M_SUBACT  = 5'h02;
   localparam [4:0] M_STOP    = 5'h04;
   localparam [4:0] M_WATCH   = 5'h08;
   localparam [4:0] M_STANDBY = 5'h10;

   reg  [4:0] mode_q;
   reg  [4:0] mode_d;
   reg  [4:0] ctrl_q;
   reg        stop_clr_q;
   reg        wdt_rst_q;
   reg        stop_clr_rst_q;

   wire [13:0] jmp_addr;
   wire [13:0] page_addr;
   wire [13:0] zpage_addr;

   wire watch_sel  = ctrl_q[`CSEQ_CTRL_WSEL];
   wire low_speed  = ctrl_q[`CSEQ_CTRL_LOWSPD];
   wire direct_xfr = ctrl_q[`CSEQ_CTRL_DIRXFR];
   wire in_stop    = mode_q[2];
   wire running    = mode_q[0] | mode_q[1];

   // Watchdog and stop clear reset the mode, PC, stack and control state; the stop clear
   // path is registered so the flop that asserts it is not self-clearing
   wire core_rst = rst_i | wdt_rst_q | stop_clr_rst_q;

   cseq_addr_gen u_addr (
      .ram_mode_i   (ram_mode_i),
      .w_reg_i      (w_reg_i),
      .x_reg_i      (x_reg_i),
      .y_reg_i      (y_reg_i),
      .word1_i      (word1_i),
      .word2_i      (word2_i),
      .pc_i         (pc_o),
      .acc_i        (acc_i),
      .b_reg_i      (b_reg_i),
      .ram_addr_o   (ram_addr_o),
      .jmp_addr_o   (jmp_addr),
      .page_addr_o  (page_addr),
      .zpage_addr_o (zpage_addr),
      .tbl_addr_o   (tbl_addr_o)
   );

   // ----------------------------------------------------------------
   // Reset sources
   // ----------------------------------------------------------------
   // One-cycle pulses; each drops out through its own feedback term, as only rst_i resets the block
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wdt_rst_q      <= 1'b0;
         stop_clr_rst_q <= 1'b0;
      end else begin
         wdt_rst_q      <= wdt_overflow_i & ctrl_q[`CSEQ_CTRL_WDEN]
                           & ~wdt_rst_q;
         stop_clr_rst_q <= in_stop & ~stop_clear_pin_n_i
                           & ~stop_clr_rst_q;
      end
   end

   // Remembers why the last reset happened: stop clear or not
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stop_clr_q <= 1'b0;
      end else if (wdt_rst_q) begin
         stop_clr_q <= 1'b0;
      end else if (stop_clr_rst_q) begin
         stop_clr_q <= 1'b1;
      end
   end

   // RAM-valid is cleared by pin or watchdog reset, set by stop clear
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ram_valid_flag_o <= 1'b0;
      end else if (wdt_rst_q) begin
         ram_valid_flag_o <= 1'b0;
      end else if (stop_clr_rst_q) begin
         ram_valid_flag_o <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Mode transitions
   // ----------------------------------------------------------------
   always @* begin
      mode_d = mode_q;
      case (mode_q)
         M_ACTIVE: begin
            // Stop mode is only left through a reset source
            if (instr_done_i && op_i == `CSEQ_OP_STOP) begin
               mode_d = watch_sel ? M_WATCH : M_STOP;
            end else if (instr_done_i && op_i == `CSEQ_OP_SLEEP) begin
               mode_d = M_STANDBY;
            end
         end
         // Low-speed clear with direct transfer set is the one
         // subactive stop or sleep that goes back to active
         M_SUBACT: begin
            if (instr_done_i && (op_i == `CSEQ_OP_STOP ||
                                 op_i == `CSEQ_OP_SLEEP) &&
                (low_speed || !direct_xfr)) begin
               mode_d = M_WATCH;
            end else if (instr_done_i && (op_i == `CSEQ_OP_STOP ||
                                          op_i == `CSEQ_OP_SLEEP)) begin
               mode_d = M_ACTIVE;
            end
         end
         // Only the INT0 or timer A wake request ends watch mode
         M_WATCH: begin
            if (wake_irq_i) begin
               mode_d = low_speed ? M_SUBACT : M_ACTIVE;
            end
         end
         // Standby wakes on any request, enabled or not, so a masked
         // source still restarts the CPU clock
         M_STANDBY: begin
            if (irq_req_i) begin
               mode_d = M_ACTIVE;
            end
         end
         // No exit here: stop clear and the reset pin both go through
         // core_rst, which forces active mode
         M_STOP: begin
            mode_d = M_STOP;
         end
         // Illegal codes fall back to active rather than hang
         default: begin
            mode_d = M_ACTIVE;
         end
      endcase
   end

   always @(posedge core_clk_i or posedge core_rst) begin
      if (core_rst) begin
         mode_q <= M_ACTIVE;
      end else begin
         mode_q <= mode_d;
      end
   end

   assign mode_o         = mode_q;
   assign cpu_clk_en_o   = running;
   assign sub_clk_sel_o  = mode_q[1] | mode_q[3];
   assign adc_halt_o     = mode_q[1] | mode_q[2] | mode_q[3];
   assign sys_osc_en_o   = mode_q[0] | mode_q[4];
   assign periph_reset_o = in_stop | core_rst;

   // ----------------------------------------------------------------
   // Program counter, stack and table fetch
   // ----------------------------------------------------------------
   // Interrupts wait for instruction end and are taken in place of the
   // instruction's own flow change, which is dropped, never during reset
   wire take_irq = running & instr_done_i & irq_req_i
                   & global_irq_enable_o;
   wire do_op    = running & instr_done_i & ~take_irq;

   always @(posedge core_clk_i or posedge core_rst) begin
      if (core_rst) begin
         pc_o          <= `CSEQ_PC_RESET;
         sp_o          <= `CSEQ_SP_RESET;
         push_o        <= 1'b0;
         push_data_o   <= 16'h0000;
         tbl_data_o    <= 8'h00;
         tbl_to_ab_o   <= 1'b0;
         tbl_to_port_o <= 1'b0;
      end else begin
         push_o        <= 1'b0;
         tbl_to_ab_o   <= 1'b0;
         tbl_to_port_o <= 1'b0;
         if (take_irq) begin
            push_o      <= 1'b1;
            push_data_o <= {pc_o, carry_flag_i, status_flag_i};
            sp_o        <= {`CSEQ_SP_TOP,
                            sp_o[5:0] - 6'h04};
            pc_o        <= irq_vector_i;
         end else if (do_op) begin
            case (op_i)
               `CSEQ_OP_SEQ: pc_o <= pc_o + 14'h0001;
               `CSEQ_OP_CALL: begin
                  if (cond_i) begin
                     push_o      <= 1'b1;
                     push_data_o <= {pc_o + 14'h0001,
                                     carry_flag_i, status_flag_i};
                     sp_o        <= {`CSEQ_SP_TOP,
                                     sp_o[5:0] - 6'h04};
                     pc_o        <= jmp_addr;
                  end else begin
                     pc_o <= pc_o + 14'h0001;
                  end
               end
               `CSEQ_OP_RET: begin
                  sp_o <= {`CSEQ_SP_TOP, sp_o[5:0] + 6'h04};
                  pc_o <= rom_data_i[3:0] == 4'h0 ?
                          {word1_i[3:0], word2_i} : jmp_addr;
               end
               `CSEQ_OP_LJMP: pc_o <= jmp_addr;
               `CSEQ_OP_BR:
                  pc_o <= cond_i ? page_addr : pc_o + 14'h0001;
               `CSEQ_OP_BRZ: pc_o <= zpage_addr;
               `CSEQ_OP_TBL: begin
                  tbl_data_o    <= rom_data_i[7:0];
                  tbl_to_ab_o   <= rom_data_i[8];
                  tbl_to_port_o <= rom_data_i[9];
               end
               `CSEQ_OP_RSPCLR: sp_o <= `CSEQ_SP_RESET;
               default: pc_o <= pc_o;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register and register port
   // ----------------------------------------------------------------
   // Interrupt entry drops the enable; a bus write in the same cycle wins
   always @(posedge core_clk_i or posedge core_rst) begin
      if (core_rst) begin
         ctrl_q              <= `CSEQ_CTRL_RESET;
         global_irq_enable_o <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == `CSEQ_REG_CTRL) begin
         ctrl_q              <= reg_wdata_i[4:0];
         global_irq_enable_o <= reg_wdata_i[`CSEQ_CTRL_IRQEN];
      end else if (take_irq) begin
         global_irq_enable_o <= 1'b0;
      end
   end

   // Read data is cleared between reads so stale values never stand
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `CSEQ_REG_CTRL: reg_rdata_o <= {3'b000, global_irq_enable_o,
                                            ctrl_q[3:0]};
            `CSEQ_REG_STAT: reg_rdata_o <= {1'b0, stop_clr_q,
                                            ram_valid_flag_o, mode_q};
            `CSEQ_REG_PC:   reg_rdata_o <= pc_o[7:0];
            `CSEQ_REG_SP:   reg_rdata_o <= sp_o[7:0];
            default:        reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end
endmodule // cseq_core

`default_nettype wire

// ===== src/cseq_defines.vh
/*
 * Constants for the CPU sequencer and reset block: widths, reset values,
 * address bases, mode codes and register-bus offsets.
 * Assumes inclusion by its bare name from the sequencer design files.
 */
`ifndef CSEQ_DEFINES_VH
`define CSEQ_DEFINES_VH

`define CSEQ_PC_W          14
`define CSEQ_SP_W          10
`define CSEQ_RAM_W         10
`define CSEQ_PC_RESET      14'h0000
`define CSEQ_SP_RESET      10'h3ff
`define CSEQ_SP_TOP        4'hf
`define CSEQ_SP_STEP       10'h004
`define CSEQ_MEMREG_BASE   6'h04

// Operation codes presented on the sequencer op port
`define CSEQ_OP_NONE       4'h0
`define CSEQ_OP_SEQ        4'h1
`define CSEQ_OP_CALL       4'h2
`define CSEQ_OP_RET        4'h3
`define CSEQ_OP_LJMP       4'h4
`define CSEQ_OP_BR         4'h5
`define CSEQ_OP_BRZ        4'h6
`define CSEQ_OP_TBL        4'h7
`define CSEQ_OP_STOP       4'h8
`define CSEQ_OP_SLEEP      4'h9
`define CSEQ_OP_RSPCLR     4'ha

// RAM addressing mode select
`define CSEQ_AM_IND        2'h0
`define CSEQ_AM_DIR        2'h1
`define CSEQ_AM_MREG       2'h2

// Register bus offsets
`define CSEQ_REG_CTRL      4'h0
`define CSEQ_REG_STAT      4'h1
`define CSEQ_REG_PC        4'h2
`define CSEQ_REG_SP        4'h3

// Control register field positions
`define CSEQ_CTRL_WSEL     0
`define CSEQ_CTRL_LOWSPD   1
`define CSEQ_CTRL_DIRXFR   2
`define CSEQ_CTRL_WDEN     3
`define CSEQ_CTRL_IRQEN    4
`define CSEQ_CTRL_RESET    5'h00

`endif

// ===== src/cseq_addr_gen.v
/*
 * RAM and ROM address formation for all addressing modes.
 * Assumes opcode fields are presented combinationally by the decoder.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cseq_defines.vh"

module cseq_addr_gen (
   input  wire [1:0]  ram_mode_i,
   input  wire [1:0]  w_reg_i,
   input  wire [3:0]  x_reg_i,
   input  wire [3:0]  y_reg_i,
   input  wire [9:0]  word1_i,
   input  wire [9:0]  word2_i,
   input  wire [13:0] pc_i,
   input  wire [3:0]  acc_i,
   input  wire [3:0]  b_reg_i,
   output reg  [9:0]  ram_addr_o,
   output wire [13:0] jmp_addr_o,
   output wire [13:0] page_addr_o,
   output wire [13:0] zpage_addr_o,
   output wire [13:0] tbl_addr_o
);
   always @* begin
      case (ram_mode_i)
         `CSEQ_AM_IND: ram_addr_o = {w_reg_i, x_reg_i, y_reg_i};
         `CSEQ_AM_DIR: ram_addr_o = word2_i;
         `CSEQ_AM_MREG: ram_addr_o = {`CSEQ_MEMREG_BASE, word1_i[3:0]};
         default:      ram_addr_o = {w_reg_i, x_reg_i, y_reg_i};
      endcase
   end

   assign jmp_addr_o   = {word1_i[3:0], word2_i};
   assign page_addr_o  = {pc_i[13:8], word1_i[7:0]};
   assign zpage_addr_o = {8'h00, word1_i[5:0]};
   // Table address: 12 bits, upper two ROM bits held at zero
   assign tbl_addr_o   = {2'b00, word1_i[3:0], acc_i, b_reg_i};
endmodule // cseq_addr_gen

`default_nettype wire

// ===== verification/cseq_core_properties.sv
/* Port-level checker for cseq_core: sequencing, stack and reset timing.
   Assumes the core's op and mode encodings; bound to every core below. */
`timescale 1ns/1ps
`default_nettype none
`include "cseq_defines.vh"
module cseq_core_props (
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire logic        instr_done_i,
   input wire logic [3:0]  op_i,
   input wire logic        cond_i,
   input wire logic [1:0]  ram_mode_i,
   input wire logic [9:0]  word1_i,
   input wire logic [9:0]  word2_i,
   input wire logic [1:0]  w_reg_i,
   input wire logic [3:0]  x_reg_i,
   input wire logic [3:0]  y_reg_i,
   input wire logic        carry_flag_i,
   input wire logic        status_flag_i,
   input wire logic        irq_req_i,
   input wire logic [13:0] irq_vector_i,
   input wire logic [13:0] pc_o,
   input wire logic [9:0]  sp_o,
   input wire logic [9:0]  ram_addr_o,
   input wire logic        push_o,
   input wire logic [15:0] push_data_o,
   input wire logic        ram_valid_flag_o,
   input wire logic        global_irq_enable_o,
   input wire logic [4:0]  mode_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // An op only counts when no enabled interrupt steals the slot
   wire tk = instr_done_i && (mode_o == 5'h01 || mode_o == 5'h02)
             && !(irq_req_i && global_irq_enable_o);
   property p_sp_top;
      sp_o[9:6] == `CSEQ_SP_TOP;
   endproperty
   property p_call;
      tk && op_i == `CSEQ_OP_CALL && cond_i
         |=> push_o && sp_o[5:0] == $past(sp_o[5:0]) - 6'h04;
   endproperty
   property p_ret;
      tk && op_i == `CSEQ_OP_RET |=> sp_o[5:0] == $past(sp_o[5:0]) + 6'h04;
   endproperty
   property p_irq;
      instr_done_i && mode_o == 5'h01 && irq_req_i && global_irq_enable_o
         |=> push_o && pc_o == $past(irq_vector_i)
             && push_data_o[1:0] == {$past(carry_flag_i), $past(status_flag_i)};
   endproperty
   property p_ram;
      ram_mode_i != 2'h3 |-> ram_addr_o == (ram_mode_i == 2'h0 ?
         {w_reg_i, x_reg_i, y_reg_i} : ram_mode_i == 2'h1 ? word2_i :
         {`CSEQ_MEMREG_BASE, word1_i[3:0]});
   endproperty
   property p_long_jump_instr;
      tk && op_i == `CSEQ_OP_LJMP
         |=> pc_o == {$past(word1_i[3:0]), $past(word2_i)};
   endproperty
   property p_br;
      tk && op_i == `CSEQ_OP_BR && cond_i
         |=> pc_o == {$past(pc_o[13:8]), $past(word1_i[7:0])};
   endproperty
   // Reset values must show while the pin is still held
   property p_rst;
      disable iff (1'b0) rst_i |-> pc_o == `CSEQ_PC_RESET
         && sp_o == `CSEQ_SP_RESET && mode_o == 5'h01
         && !ram_valid_flag_o && !global_irq_enable_o;
   endproperty
   a_sp_top: assert property (p_sp_top) else $error("sp top bits");
   a_call: assert property (p_call) else $error("call stack step");
   a_ret: assert property (p_ret) else $error("return stack step");
   a_irq: assert property (p_irq) else $error("irq entry");
   a_ram: assert property (p_ram) else $error("ram addr");
   a_long_jump_instr: assert property (p_long_jump_instr) else $error("long jump");
   a_br: assert property (p_br) else $error("page branch");
   a_rst: assert property (p_rst) else $error("reset values");
   c_call: cover property (tk && op_i == `CSEQ_OP_CALL);
   c_sub: cover property (mode_o == 5'h02);
   c_stop: cover property (mode_o == 5'h04);
endmodule // cseq_core_props
bind cseq_core cseq_core_props u_props (
   .core_clk_i, .rst_i, .instr_done_i, .op_i, .cond_i, .ram_mode_i,
   .word1_i, .word2_i, .w_reg_i, .x_reg_i, .y_reg_i, .carry_flag_i,
   .status_flag_i, .irq_req_i, .irq_vector_i, .pc_o, .sp_o, .ram_addr_o,
   .push_o, .push_data_o, .ram_valid_flag_o, .global_irq_enable_o, .mode_o
);
`default_nettype wire

// ===== verification/cseq_core_tb_top.sv
/* Directed bench for cseq_core: sequencing, stack, modes and resets.
   Assumes the core header and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "cseq_defines.vh"
module cpu_sequencer_and_reset_tb_top;
   logic        core_clk_i, rst_i, wdt_overflow_i, stop_clear_pin_n_i;
   logic        instr_done_i, cond_i, carry_flag_i, status_flag_i;
   logic        irq_req_i, wake_irq_i, reg_wr_i, reg_rd_i;
   logic [3:0]  op_i, x_reg_i, y_reg_i, acc_i, b_reg_i, reg_addr_i;
   logic [1:0]  ram_mode_i, w_reg_i;
   logic [9:0]  word1_i, word2_i, rom_data_i;
   logic [13:0] irq_vector_i;
   logic [7:0]  reg_wdata_i, rd;
   logic [5:0]  e;
   wire  [7:0]  reg_rdata_o, tbl_data_o;
   wire  [13:0] pc_o, tbl_addr_o;
   wire  [9:0]  sp_o, ram_addr_o;
   wire  [15:0] push_data_o;
   wire  [4:0]  mode_o;
   wire         push_o, tbl_to_ab_o, tbl_to_port_o, ram_valid_flag_o;
   wire         global_irq_enable_o, cpu_clk_en_o, sub_clk_sel_o;
   wire         sys_osc_en_o, periph_reset_o, adc_halt_o;
   int          fail_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   cseq_core DUT (
      .core_clk_i, .rst_i, .wdt_overflow_i, .stop_clear_pin_n_i,
      .instr_done_i, .op_i, .ram_mode_i, .word1_i, .word2_i, .cond_i,
      .w_reg_i, .x_reg_i, .y_reg_i, .acc_i, .b_reg_i, .rom_data_i,
      .carry_flag_i, .status_flag_i, .irq_req_i, .irq_vector_i,
      .wake_irq_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .pc_o, .sp_o, .ram_addr_o, .tbl_addr_o, .push_o,
      .push_data_o, .tbl_data_o, .tbl_to_ab_o, .tbl_to_port_o,
      .ram_valid_flag_o, .global_irq_enable_o, .cpu_clk_en_o,
      .sub_clk_sel_o, .sys_osc_en_o, .periph_reset_o, .adc_halt_o, .mode_o
   );
   // ----
   // Helpers
   // ----
   task automatic tick();
      @(posedge core_clk_i);
   endtask
   task automatic check(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("%0d checks, %0d mismatches", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      tick();
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      tick();
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a);
      tick();
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      tick();
      reg_rd_i <= 1'b0;
      #1 rd = reg_rdata_o;
   endtask
   task automatic do_op(input logic [3:0] o, input logic [9:0] a, b);
      tick();
      instr_done_i <= 1'b1;
      op_i <= o;
      word1_i <= a;
      word2_i <= b;
      tick();
      instr_done_i <= 1'b0;
      #1;
   endtask
   // Bounded wait; a mode that never arrives fails the compare
   task automatic wait_mode(input logic [4:0] m);
      for (int i = 0; i < 20 && mode_o !== m; i++)
         tick();
      #1 check(mode_o, m);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_basic();
      check({pc_o, ram_valid_flag_o, global_irq_enable_o}, 16'h0000);
      check({sp_o, mode_o}, {10'h3ff, 5'h01});
      rdr(`CSEQ_REG_STAT);
      check(rd[5:0], 6'h01);
      rdr(4'hf);
      check(rd, 8'h00);
      do_op(`CSEQ_OP_SEQ, 10'h000, 10'h000);
      check(pc_o, 14'h0001);
      do_op(`CSEQ_OP_LJMP, 10'h3a5, 10'h2c3);
      check(pc_o, 14'h16c3);
      do_op(`CSEQ_OP_BR, 10'h37e, 10'h000);
      check(pc_o, 14'h167e);
      do_op(`CSEQ_OP_BRZ, 10'h3ff, 10'h000);
      check(pc_o, 14'h003f);
      rdr(`CSEQ_REG_PC);
      check(rd, 8'h3f);
      $display("test basic done");
   endtask
   task automatic t_stack();
      e = 6'h3f;
      for (int i = 0; i < 17; i++) begin
         do_op(`CSEQ_OP_CALL, 10'h001, 10'h100);
         e = e - 6'h04;
         check(sp_o, {4'hf, e});
         check({push_o, push_data_o[1:0], pc_o}, 17'h18500);
         check(push_data_o[15:2], i == 0 ? 14'h0040 : 14'h0501);
      end
      do_op(`CSEQ_OP_RET, 10'h003, 10'h155);
      check({sp_o, pc_o[5:0]}, {4'hf, e + 6'h04, 6'h15});
      do_op(`CSEQ_OP_RSPCLR, 10'h000, 10'h000);
      check(sp_o, 10'h3ff);
      $display("test stack done");
   endtask
   task automatic t_addr();
      {w_reg_i, x_reg_i, y_reg_i} <= 10'h2a5;
      {acc_i, b_reg_i} <= 8'h96;
      for (int m = 0; m < 3; m++) begin
         ram_mode_i <= m[1:0];
         word1_i <= 10'h3c7;
         word2_i <= 10'h19b;
         tick();
         #1 check(ram_addr_o, m == 0 ? 10'h2a5 : m == 1 ? 10'h19b : 10'h047);
      end
      check(tbl_addr_o[13:8], 6'h07);
      do_op(`CSEQ_OP_LJMP, 10'h000, 10'h123);
      for (int i = 0; i < 4; i++) begin
         rom_data_i <= {i[1:0], 8'h5a ^ i[7:0]};
         do_op(`CSEQ_OP_TBL, 10'h000, 10'h000);
         check({tbl_to_port_o, tbl_to_ab_o, pc_o}, {i[1:0], 14'h0123});
         if (i != 0)
            check(tbl_data_o, 8'h5a ^ i[7:0]);
      end
      $display("test addressing done");
   endtask
   task automatic t_irq();
      wr(`CSEQ_REG_CTRL, 8'h10);
      irq_vector_i <= 14'h0006;
      irq_req_i <= 1'b1;
      do_op(`CSEQ_OP_SEQ, 10'h000, 10'h000);
      check({pc_o, push_o, global_irq_enable_o}, 16'h001a);
      check(sp_o, 10'h3fb);
      do_op(`CSEQ_OP_SEQ, 10'h000, 10'h000);
      irq_req_i <= 1'b0;
      check({pc_o, push_o}, 15'h000e);
      $display("test interrupt done");
   endtask
   task automatic t_power();
      do_op(`CSEQ_OP_SLEEP, 10'h000, 10'h000);
      check({mode_o, cpu_clk_en_o}, 6'h20);
      irq_req_i <= 1'b1;
      wait_mode(5'h01);
      irq_req_i <= 1'b0;
      wr(`CSEQ_REG_CTRL, 8'h01);
      do_op(`CSEQ_OP_STOP, 10'h000, 10'h000);
      check({mode_o, sys_osc_en_o}, 6'h10);
      wr(`CSEQ_REG_CTRL, 8'h03);
      wake_irq_i <= 1'b1;
      tick();
      wake_irq_i <= 1'b0;
      wait_mode(5'h02);
      check({sub_clk_sel_o, adc_halt_o}, 2'b11);
      wr(`CSEQ_REG_CTRL, 8'h04);
      do_op(`CSEQ_OP_SLEEP, 10'h000, 10'h000);
      check(mode_o, 5'h01);
      wr(`CSEQ_REG_CTRL, 8'h00);
      do_op(`CSEQ_OP_STOP, 10'h000, 10'h000);
      check({mode_o, sys_osc_en_o, periph_reset_o}, 7'h11);
      stop_clear_pin_n_i <= 1'b0;
      wait_mode(5'h01);
      stop_clear_pin_n_i <= 1'b1;
      check({pc_o, ram_valid_flag_o}, 15'h0001);
      $display("test low power done");
   endtask
   task automatic t_resets();
      do_op(`CSEQ_OP_LJMP, 10'h001, 10'h0aa);
      for (int en = 0; en < 2; en++) begin
         wr(`CSEQ_REG_CTRL, en == 0 ? 8'h00 : 8'h08);
         wdt_overflow_i <= 1'b1;
         tick();
         wdt_overflow_i <= 1'b0;
         repeat (3) tick();
         #1 check({pc_o, ram_valid_flag_o}, en == 0 ? 15'h0955 : 15'h0000);
      end
      do_op(`CSEQ_OP_LJMP, 10'h002, 10'h011);
      tick();
      rst_i <= 1'b1;
      #1 check(pc_o, 14'h0000);
      repeat (8) tick();
      rst_i <= 1'b0;
      do_op(`CSEQ_OP_SEQ, 10'h000, 10'h000);
      check({pc_o, mode_o}, {14'h0001, 5'h01});
      $display("test resets done");
   endtask
   // ----
   // Clock, timeout and main sequence
   // ----
   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      {rst_i, stop_clear_pin_n_i, cond_i, carry_flag_i} = 4'hf;
      {wdt_overflow_i, instr_done_i, status_flag_i, irq_req_i} = 4'h0;
      {wake_irq_i, reg_wr_i, reg_rd_i, op_i, reg_addr_i} = 11'h000;
      {x_reg_i, y_reg_i, acc_i, b_reg_i, ram_mode_i, w_reg_i} = 20'h00000;
      {word1_i, word2_i, rom_data_i} = 30'h00000000;
      irq_vector_i = 14'h0000;
      reg_wdata_i = 8'h00;
      repeat (16) tick();
      rst_i <= 1'b0;
      #1;
      t_basic();
      t_stack();
      t_addr();
      t_irq();
      t_power();
      t_resets();
      print_verdict();
   end
endmodule // cpu_sequencer_and_reset_tb_top
`default_nettype wire
